//--- include/sps_regs.svh
// register map, field positions, reset values and timing of the position supervisor
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SPS_OFS_CTRL       8'h00
`define SPS_OFS_TMOVE_ON   8'h04
`define SPS_OFS_TMOVE_OFF  8'h08
`define SPS_OFS_STATUS     8'h0C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SPS_CTRL_ON_CMD    0
`define SPS_CTRL_OFF_CMD   1
`define SPS_CTRL_CL_WIRED  2
`define SPS_CTRL_OP_WIRED  3
`define SPS_CTRL_ROUTE     4

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define SPS_ST_CLOSED      0
`define SPS_ST_OPEN        1
`define SPS_ST_TRANSIT     2
`define SPS_ST_FAULT       3
`define SPS_ST_CODE_LO     4
`define SPS_ST_CODE_HI     5
`define SPS_ST_SINGLE      6
`define SPS_ST_SUCCESS     7
`define SPS_ST_AUX_CL      8
`define SPS_ST_AUX_OP      9

// ----------------------------------------------------------------
// position codes
// ----------------------------------------------------------------
`define SPS_CODE_INTER     2'h0
`define SPS_CODE_OPEN      2'h1
`define SPS_CODE_CLOSED    2'h2
`define SPS_CODE_DISTURB   2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPS_RST_CL_WIRED   1'h1
`define SPS_RST_OP_WIRED   1'h1
`define SPS_RST_ROUTE      1'h0
`define SPS_RST_TMOVE      16'h0064

// ----------------------------------------------------------------
// time base: travel times count in units of this period
// ----------------------------------------------------------------
`define SPS_CLK_NS         20
`define SPS_TICK_NS        1000000
`define SPS_TICK_CYCLES    ((`SPS_TICK_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)

`endif

//--- include/sps_pkg.sv
// types shared by the position supervisor and its travel timer
package sps_pkg;

    // ----------------------------------------------------------------
    // supervision states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0001,
        ST_MOVE_ON  = 4'b0010,
        ST_MOVE_OFF = 4'b0100,
        ST_EXPIRED  = 4'b1000
    } sps_state_t;

    // ----------------------------------------------------------------
    // bus carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sps_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sps_apb_rsp_t;

    // ----------------------------------------------------------------
    // validated position
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       closed;
        logic       open;
        logic       transit;
        logic       fault;
        logic [1:0] code;
        logic       single_contact_flag;
        logic       success_flag;
    } sps_pos_t;

    // ----------------------------------------------------------------
    // command outputs to the relays
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ctl_on;
        logic ctl_off;
        logic prot_on;
        logic prot_off;
    } sps_cmd_t;

    // ----------------------------------------------------------------
    // module states
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic        running;
        logic        expired;
    } sps_tmr_t;

    typedef struct packed {
        sps_state_t  st;
        logic        supervised;
        logic        from_prot;
        logic [1:0]  sync_cl;
        logic [1:0]  sync_op;
        logic [15:0] presc;
        logic        tick;
        logic        cl_wired;
        logic        op_wired;
        logic        route;
        logic [15:0] tmove_on;
        logic [15:0] tmove_off;
        logic [31:0] rdata;
        logic        rerr;
        sps_pos_t    pos;
        sps_cmd_t    cmd;
    } sps_core_t;

endpackage

//--- src/sps_travel_timer.sv
// one travel timer counting time-base ticks up to a programmed limit
`timescale 1ns/1ps
`include "sps_regs.svh"

module sps_travel_timer
    import sps_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // control
    input  wire logic        i_tick,
    input  wire logic        i_start,
    input  wire logic        i_stop,
    input  wire logic [15:0] i_limit,
    // status
    output logic             o_running,
    output logic             o_expired
);

    sps_tmr_t s;
    sps_tmr_t next_s;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s         = s;
        next_s.expired = 1'b0;
        if (i_start)
        begin
            // a restart while running begins a fresh travel time
            next_s.count   = 16'h0000;
            next_s.running = 1'b1;
        end
        else if (i_stop)
        begin
            next_s.running = 1'b0;
        end
        else if (s.running && i_tick)
        begin
            if (s.count + 16'h0001 >= i_limit)
            begin
                next_s.running = 1'b0;
                next_s.expired = 1'b1;
            end
            else
            begin
                next_s.count = s.count + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_running = s.running;
    assign o_expired = s.expired;

endmodule

//--- src/sps_supervisor.sv
// switchgear position supervisor with travel timers and an APB register slave
//
// Notes on behaviour
// - one switchgear unit, one set of everything
// - protection commands may share control command outputs
// - single contact: no intermediate/disturbed from contacts
// - sample contacts, qualify with travel timers
// - code: 0 inter, 1 open, 2 closed, 3 disturbed
// - ON starts close timer, in-transit while supervised and running
// - closed feedback in time sets closed flag
// - supervised timer expiry without end position sets fault
// - OFF starts open timer; open feedback sets open
// - opposite contacts give open or closed position
// - equal contacts: transit while timing, else disturbed
// - single contact wiring raises single-contact flag
// - single contact supervises matching direction only
// - closed-only: ON travel intermediate, closed gives success
// - single contact expiry: unsuccessful, fault, no transit
// - closed-only position decode from closed contact
// - no contact assigned forces disturbed code
// - open-only: OFF supervised, open gives success
`timescale 1ns/1ps
`include "sps_regs.svh"

module sps_supervisor
    import sps_pkg::*;
#(
    parameter int TICK_CYCLES = `SPS_TICK_CYCLES
)
(
    // clock and reset
    input  wire logic   I_CORE_CLK,
    input  wire logic   I_RST,
    // register bus
    input  sps_pkg::sps_apb_req_t I_APB,
    output sps_pkg::sps_apb_rsp_t O_APB,
    // auxiliary contacts
    input  wire logic   I_AUX_CLOSED,
    input  wire logic   I_AUX_OPEN,
    // protection commands
    input  wire logic   I_PROT_ON,
    input  wire logic   I_PROT_OFF,
    // validated position
    output sps_pkg::sps_pos_t O_POS,
    // command relays
    output sps_pkg::sps_cmd_t O_CMD
);

    import sps_pkg::*;

    sps_core_t  s;
    sps_core_t  next_s;
    logic [1:0] tmr_start;
    logic [1:0] tmr_stop;
    logic [1:0] tmr_running;
    logic [1:0] tmr_expired;
    logic [1:0][15:0] tmr_limit;

    // ----------------------------------------------------------------
    // travel timers, index 0 close direction, index 1 open direction
    // ----------------------------------------------------------------
    assign tmr_limit[0] = s.tmove_on;
    assign tmr_limit[1] = s.tmove_off;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_tmr
            sps_travel_timer u_tmr (
                .i_clk     (I_CORE_CLK),
                .i_rst     (I_RST),
                .i_tick    (s.tick),
                .i_start   (tmr_start[g]),
                .i_stop    (tmr_stop[g]),
                .i_limit   (tmr_limit[g]),
                .o_running (tmr_running[g]),
                .o_expired (tmr_expired[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic        cl;
        logic        op;
        logic        bus_wr;
        logic        bus_setup;
        logic        want_on;
        logic        want_off;
        logic        cmd_prot;
        logic        both;
        logic        cl_only;
        logic        op_only;
        logic        moving;
        logic        end_on;
        logic        end_off;
        logic        end_any;
        logic        expire;
        logic [31:0] rd;
        sps_pos_t    p;

        next_s    = s;
        tmr_start = 2'h0;
        tmr_stop  = 2'h0;
        cl        = s.sync_cl[1];
        op        = s.sync_op[1];
        bus_wr    = I_APB.psel && I_APB.penable && I_APB.pwrite;
        bus_setup = I_APB.psel && !I_APB.penable;
        rd        = 32'h0000_0000;
        p         = '0;
        want_on   = 1'b0;
        want_off  = 1'b0;
        cmd_prot  = 1'b0;
        moving    = 1'b0;
        expire    = 1'b0;

        // wiring modes and the end positions each of them can see
        both      = s.cl_wired && s.op_wired;
        cl_only   = s.cl_wired && !s.op_wired;
        op_only   = !s.cl_wired && s.op_wired;
        end_on    = both ? (cl && !op) : (cl_only && cl);
        end_off   = both ? (op && !cl) : (op_only && op);
        end_any   = both ? (cl != op) : ((cl_only && cl) || (op_only && op));

        // two-stage synchronisers; only the second stage is looked at
        next_s.sync_cl = {s.sync_cl[0], I_AUX_CLOSED};
        next_s.sync_op = {s.sync_op[0], I_AUX_OPEN};

        // time-base prescaler
        next_s.tick = 1'b0;
        if (s.presc >= 16'(TICK_CYCLES - 1))
        begin
            next_s.presc = 16'h0000;
            next_s.tick  = 1'b1;
        end
        else
        begin
            next_s.presc = s.presc + 16'h0001;
        end

        // register writes, taken in the access phase
        if (bus_wr)
        begin
            case (I_APB.paddr)
                `SPS_OFS_CTRL:
                begin
                    want_on        = I_APB.pwdata[`SPS_CTRL_ON_CMD];
                    want_off       = I_APB.pwdata[`SPS_CTRL_OFF_CMD];
                    next_s.cl_wired = I_APB.pwdata[`SPS_CTRL_CL_WIRED];
                    next_s.op_wired = I_APB.pwdata[`SPS_CTRL_OP_WIRED];
                    next_s.route    = I_APB.pwdata[`SPS_CTRL_ROUTE];
                end
                `SPS_OFS_TMOVE_ON:  next_s.tmove_on  = I_APB.pwdata[15:0];
                `SPS_OFS_TMOVE_OFF: next_s.tmove_off = I_APB.pwdata[15:0];
                default: ;
            endcase
        end
        cmd_prot = (I_PROT_ON || I_PROT_OFF) && !want_on && !want_off;
        want_on  = want_on || I_PROT_ON;
        want_off = want_off || I_PROT_OFF;

        // supervision sequence
        case (s.st)
            ST_MOVE_ON:
            begin
                if (s.supervised && end_on)
                begin
                    next_s.st               = ST_IDLE;
                    next_s.pos.success_flag = 1'b1;
                    tmr_stop[0]             = 1'b1;
                end
                else if (tmr_expired[0])
                begin
                    expire    = s.supervised;
                    next_s.st = s.supervised ? ST_EXPIRED : ST_IDLE;
                end
            end
            ST_MOVE_OFF:
            begin
                if (s.supervised && end_off)
                begin
                    next_s.st               = ST_IDLE;
                    next_s.pos.success_flag = 1'b1;
                    tmr_stop[1]             = 1'b1;
                end
                else if (tmr_expired[1])
                begin
                    expire    = s.supervised;
                    next_s.st = s.supervised ? ST_EXPIRED : ST_IDLE;
                end
            end
            ST_EXPIRED:
            begin
                // a later valid end position ends the disturbance
                if (end_any)
                begin
                    next_s.st = ST_IDLE;
                end
            end
            ST_IDLE: ;
            default:
            begin
                next_s.st = ST_IDLE;
            end
        endcase

        // a new command restarts supervision; OFF wins over ON
        if (want_off)
        begin
            next_s.st               = ST_MOVE_OFF;
            next_s.supervised       = both || op_only;
            next_s.from_prot        = cmd_prot;
            next_s.pos.success_flag = 1'b0;
            tmr_start[1]            = 1'b1;
            tmr_stop[0]             = 1'b1;
        end
        else if (want_on)
        begin
            next_s.st               = ST_MOVE_ON;
            next_s.supervised       = both || cl_only;
            next_s.from_prot        = cmd_prot;
            next_s.pos.success_flag = 1'b0;
            tmr_start[0]            = 1'b1;
            tmr_stop[1]             = 1'b1;
        end
        if (expire)
        begin
            next_s.pos.success_flag = 1'b0;
        end

        // position decode from the next state and contacts
        moving = (next_s.st == ST_MOVE_ON || next_s.st == ST_MOVE_OFF)
                 && next_s.supervised;
        if (both)
        begin
            if (cl != op)
            begin
                p.closed = cl;
                p.open   = op;
                p.code   = cl ? `SPS_CODE_CLOSED : `SPS_CODE_OPEN;
            end
            else if (moving)
            begin
                p.transit = 1'b1;
                p.code    = `SPS_CODE_INTER;
            end
            else
            begin
                p.fault = 1'b1;
                p.code  = `SPS_CODE_DISTURB;
            end
        end
        else if (cl_only || op_only)
        begin
            // one contact cannot itself tell intermediate from the other end
            if (cl_only ? cl : op)
            begin
                p.closed = cl_only;
                p.open   = op_only;
                p.code   = cl_only ? `SPS_CODE_CLOSED : `SPS_CODE_OPEN;
            end
            else if (moving)
            begin
                p.transit = 1'b1;
                p.code    = `SPS_CODE_INTER;
            end
            else if (next_s.st == ST_EXPIRED)
            begin
                p.fault = 1'b1;
                p.code  = `SPS_CODE_DISTURB;
            end
            else
            begin
                p.closed = op_only;
                p.open   = cl_only;
                p.code   = cl_only ? `SPS_CODE_OPEN : `SPS_CODE_CLOSED;
            end
        end
        else
        begin
            p.fault = 1'b1;
            p.code  = `SPS_CODE_DISTURB;
        end
        p.single_contact_flag = s.cl_wired != s.op_wired;
        p.success_flag        = next_s.pos.success_flag;
        next_s.pos            = p;

        // relay drive lasts until the supervised end position is reached or the travel time of the command runs out
        next_s.cmd = '0;
        if (next_s.st == ST_MOVE_ON || next_s.st == ST_MOVE_OFF)
        begin
            if (next_s.from_prot && !next_s.route)
            begin
                next_s.cmd.prot_on  = next_s.st == ST_MOVE_ON;
                next_s.cmd.prot_off = next_s.st == ST_MOVE_OFF;
            end
            else
            begin
                next_s.cmd.ctl_on  = next_s.st == ST_MOVE_ON;
                next_s.cmd.ctl_off = next_s.st == ST_MOVE_OFF;
            end
        end

        // read data is captured in the setup phase
        rd[`SPS_ST_CLOSED]  = s.pos.closed;
        rd[`SPS_ST_OPEN]    = s.pos.open;
        rd[`SPS_ST_TRANSIT] = s.pos.transit;
        rd[`SPS_ST_FAULT]   = s.pos.fault;
        rd[`SPS_ST_CODE_HI:`SPS_ST_CODE_LO] = s.pos.code;
        rd[`SPS_ST_SINGLE]  = s.pos.single_contact_flag;
        rd[`SPS_ST_SUCCESS] = s.pos.success_flag;
        rd[`SPS_ST_AUX_CL]  = cl;
        rd[`SPS_ST_AUX_OP]  = op;
        if (bus_setup)
        begin
            next_s.rerr  = 1'b0;
            next_s.rdata = 32'h0000_0000;
            case (I_APB.paddr)
                `SPS_OFS_CTRL:
                begin
                    next_s.rdata[`SPS_CTRL_CL_WIRED] = s.cl_wired;
                    next_s.rdata[`SPS_CTRL_OP_WIRED] = s.op_wired;
                    next_s.rdata[`SPS_CTRL_ROUTE]    = s.route;
                end
                `SPS_OFS_TMOVE_ON:  next_s.rdata[15:0] = s.tmove_on;
                `SPS_OFS_TMOVE_OFF: next_s.rdata[15:0] = s.tmove_off;
                `SPS_OFS_STATUS:    next_s.rdata       = rd;
                default:            next_s.rerr        = 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers: every output except the constant pready and the gated pslverr moves on the same edge
    // ----------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            s           <= '0;
            s.st        <= ST_IDLE;
            s.cl_wired  <= `SPS_RST_CL_WIRED;
            s.op_wired  <= `SPS_RST_OP_WIRED;
            s.route     <= `SPS_RST_ROUTE;
            s.tmove_on  <= `SPS_RST_TMOVE;
            s.tmove_off <= `SPS_RST_TMOVE;
            s.pos.fault <= 1'b1;
            s.pos.code  <= `SPS_CODE_DISTURB;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign O_APB.prdata  = s.rdata;
    assign O_APB.pready  = 1'b1;
    // the unmapped-address error only shows while an access is in progress
    assign O_APB.pslverr = s.rerr && I_APB.psel && I_APB.penable;
    assign O_POS         = s.pos;
    assign O_CMD         = s.cmd;

endmodule

//--- dv/sps_aux_model.sv
// behavioural auxiliary contacts of one switchgear, moved by the relay outputs
`timescale 1ns/1ps
module sps_aux_model
    import sps_pkg::*;
(
    // relay side
    input  wire logic i_clk,
    input  sps_cmd_t  i_cmd,
    input  wire logic i_slow,
    // contact side
    output logic      o_closed,
    output logic      o_open
);
    logic on_q;
    logic off_q;
    logic go_on;
    logic go_off;
    logic tgt;
    int   cnt;
    assign go_on  = (i_cmd.ctl_on | i_cmd.prot_on) & !on_q;
    assign go_off = (i_cmd.ctl_off | i_cmd.prot_off) & !off_q;
    initial
    begin
        on_q     = 1'b0;
        off_q    = 1'b0;
        tgt      = 1'b0;
        cnt      = 0;
        o_closed = 1'b0;
        o_open   = 1'b1;
    end
    // ----------------------------------------------------------------
    // travel: both contacts open while moving, slow drive outlasts short timers
    // ----------------------------------------------------------------
    always @(posedge i_clk)
    begin
        on_q  <= i_cmd.ctl_on | i_cmd.prot_on;
        off_q <= i_cmd.ctl_off | i_cmd.prot_off;
        if (go_on || go_off)
        begin
            tgt      <= go_on && !go_off;
            cnt      <= i_slow ? 60 : 20;
            o_closed <= 1'b0;
            o_open   <= 1'b0;
        end
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            if (cnt == 1)
            begin
                o_closed <= tgt;
                o_open   <= !tgt;
            end
        end
    end
endmodule

//--- dv/sps_supervisor_sva.sv
// concurrent checks on the position supervisor ports
`timescale 1ns/1ps
module sps_supervisor_sva
    import sps_pkg::*;
(
    // watched ports
    input wire logic    I_CORE_CLK,
    input wire logic    I_RST,
    input sps_apb_req_t I_APB,
    input sps_apb_rsp_t O_APB,
    input wire logic    I_PROT_OFF,
    input sps_pos_t     O_POS,
    input sps_cmd_t     O_CMD
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    logic acc;
    logic wr;
    assign acc = I_APB.psel && I_APB.penable;
    assign wr  = acc && I_APB.pwrite && I_APB.paddr == 8'h00;
    // ----------------------------------------------------------------
    // position, relay and bus relations
    // ----------------------------------------------------------------
    chk_closed_code: assert property (O_POS.closed |-> O_POS.code == 2'h2)
        else $error("closed flag without code 2");
    chk_open_code: assert property (O_POS.open |-> O_POS.code == 2'h1)
        else $error("open flag without code 1");
    chk_transit_code: assert property (O_POS.transit |-> O_POS.code == 2'h0)
        else $error("transit flag without code 0");
    chk_fault_code: assert property (O_POS.fault |-> O_POS.code == 2'h3)
        else $error("fault flag without code 3");
    chk_flag_excl: assert property (
        $onehot0({O_POS.closed, O_POS.open, O_POS.transit, O_POS.fault}))
        else $error("position flags not exclusive");
    chk_on_relay: assert property (
        wr && I_APB.pwdata[1:0] == 2'b01 && !I_PROT_OFF |=> O_CMD.ctl_on)
        else $error("on command did not drive relay");
    chk_off_relay: assert property (wr && I_APB.pwdata[1] |=> O_CMD.ctl_off)
        else $error("off command did not drive relay");
    chk_prot_relay: assert property (
        I_PROT_OFF && !(acc && I_APB.pwrite) |=> O_CMD.prot_off || O_CMD.ctl_off)
        else $error("protection off did not drive a relay");
    chk_success_end: assert property (
        $rose(O_POS.success_flag) |-> O_POS.closed || O_POS.open)
        else $error("success without end position");
    chk_bus_err: assert property (
        acc |-> O_APB.pslverr == !(I_APB.paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
        else $error("bus error flag wrong");
    cover property (O_POS.success_flag && O_POS.closed);
    cover property ($fell(O_POS.transit) && O_POS.fault);
    cover property (O_POS.single_contact_flag && O_POS.open);
endmodule
bind sps_supervisor sps_supervisor_sva u_sva (.I_CORE_CLK, .I_RST, .I_APB, .O_APB, .I_PROT_OFF,
    .O_POS, .O_CMD);

//--- dv/sps_supervisor_tb_top.sv
// self-checking bench for the position supervisor
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    compares++; \
    if ((got) !== (ex)) \
    begin \
        err_count++; \
        $display("unexpected %s exp %0h got %0h", nm, ex, got); \
    end
module sps_supervisor_tb_top;
    import sps_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    sps_apb_req_t req = '0;
    sps_apb_rsp_t rsp;
    logic         aux_cl;
    logic         aux_op;
    logic         p_on = 1'b0;
    logic         p_off = 1'b0;
    logic         slow = 1'b0;
    sps_pos_t     pos;
    sps_cmd_t     cmd;
    int           err_count = 0;
    int           compares = 0;
    logic [31:0]  rd;
    logic         serr;
    always #10 clk = ~clk;
    // short time base keeps the default travel time at 400 cycles
    sps_supervisor #(.TICK_CYCLES(4)) dut (.I_CORE_CLK(clk), .I_RST(rst), .I_APB(req),
        .O_APB(rsp), .I_AUX_CLOSED(aux_cl), .I_AUX_OPEN(aux_op), .I_PROT_ON(p_on),
        .I_PROT_OFF(p_off), .O_POS(pos), .O_CMD(cmd));
    sps_aux_model u_aux (.i_clk(clk), .i_cmd(cmd), .i_slow(slow), .o_closed(aux_cl),
        .o_open(aux_op));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task end_sim;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        serr = rsp.pslverr;
        req <= '0;
        if (n >= 20)
        begin
            err_count++;
            end_sim;
        end
    endtask
    task wait_code(input logic [1:0] c, input int lim);
        for (int n = 0; n < lim && pos.code !== c; n++)
            tick(1);
        if (pos.code !== c)
        begin
            err_count++;
            end_sim;
        end
    endtask
    task pulse(input logic off);
        @(posedge clk);
        p_off <= off;
        p_on <= !off;
        @(posedge clk);
        p_off <= 1'b0;
        p_on <= 1'b0;
        #1;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task s_regs;
        `CHK("idle code", 2'h1, pos.code)
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0000000C, rd)
        apb(1'b0, 8'h04, 32'h0);
        `CHK("tmove on", 32'h00000064, rd)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped err", 1'b1, serr)
    endtask
    task s_both;
        apb(1'b1, 8'h00, 32'hD);
        // relay edge plus two sync stages before the contacts show travel
        tick(4);
        `CHK("on flags", 6'b001000, {pos.closed, pos.open, pos.transit, pos.fault, pos.code})
        wait_code(2'h2, 100);
        `CHK("closed flags", 5'b10110, {pos.closed, pos.transit, pos.success_flag, pos.code})
        apb(1'b1, 8'h00, 32'hE);
        tick(4);
        `CHK("off transit", 1'b1, pos.transit)
        wait_code(2'h1, 100);
        `CHK("open flag", 2'b10, {pos.open, pos.transit})
    endtask
    task s_single;
        apb(1'b1, 8'h00, 32'h5);
        tick(1);
        `CHK("single flag", 1'b1, pos.single_contact_flag)
        `CHK("single transit", 3'b100, {pos.transit, pos.code})
        wait_code(2'h2, 100);
        `CHK("single closed", 2'b11, {pos.closed, pos.success_flag})
        apb(1'b1, 8'h00, 32'h6);
        tick(1);
        `CHK("off relay unsupervised", 2'b01, {pos.transit, cmd.ctl_off})
        wait_code(2'h1, 100);
        `CHK("single open", 1'b1, pos.open)
        apb(1'b1, 8'h00, 32'h0);
        tick(4);
        `CHK("unassigned code", 3'b011, {pos.single_contact_flag, pos.code})
    endtask
    task s_prot_expire;
        apb(1'b1, 8'h00, 32'hC);
        pulse(1'b1);
        `CHK("prot off relay", 2'b01, {cmd.ctl_off, cmd.prot_off})
        apb(1'b1, 8'h00, 32'h1C);
        pulse(1'b0);
        `CHK("routed on relay", 2'b10, {cmd.ctl_on, cmd.prot_on})
        wait_code(2'h2, 100);
        slow = 1'b1;
        // breaker is closed here, so only an off command can run out of time
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b1, 8'h00, 32'hE);
        tick(4);
        `CHK("timing", 2'b10, {pos.transit, pos.fault})
        wait_code(2'h3, 10);
        `CHK("expired", 3'b010, {pos.transit, pos.fault, pos.success_flag})
        wait_code(2'h1, 100);
        `CHK("late open", 2'b10, {pos.open, pos.fault})
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        tick(4);
        s_regs;
        s_both;
        s_single;
        s_prot_expire;
        end_sim;
    end
endmodule
